/* hdl/pll_consts.svh */
// Offsets, field positions, reset values and timing counts of the PLL control block.
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// Register byte offsets on the peripheral bus.
`define PLL_CTRLA_OFFSET 12'h044
`define PLL_RATIO_OFFSET 12'h048
`define PLL_CTRLB_OFFSET 12'h04c
`define PLL_STATUS_OFFSET 12'h050
`define PLL_EVENT_OFFSET 12'h054

// Reset values.
`define PLL_CTRLA_RESET 32'h0000_0080
`define PLL_RATIO_RESET 32'h0000_0000
`define PLL_CTRLB_RESET 32'h0000_0000

// Writable bits of each register; everything else reads as zero.
`define PLL_CTRLA_MASK 32'h0000_0082
`define PLL_RATIO_MASK 32'h000f_0fff
`define PLL_CTRLB_MASK 32'h07ff_173f

// Field positions in the first control register.
`define PLL_CTRLA_ENABLE_BIT 1
`define PLL_CTRLA_ONREQ_BIT 7

// Field positions in the ratio register.
`define PLL_RATIO_INT_MSB 11
`define PLL_RATIO_INT_LSB 0
`define PLL_RATIO_FRAC_MSB 19
`define PLL_RATIO_FRAC_LSB 16

// Field positions in the second control register.
`define PLL_CTRLB_DIV_MSB 26
`define PLL_CTRLB_DIV_LSB 16
`define PLL_CTRLB_BYPASS_BIT 12
`define PLL_CTRLB_LOCK_TIMEOUT_SEL_MSB 10
`define PLL_CTRLB_LOCK_TIMEOUT_SEL_LSB 8
`define PLL_CTRLB_REF_MSB 5
`define PLL_CTRLB_REF_LSB 4
`define PLL_CTRLB_WUF_BIT 3
`define PLL_CTRLB_LPEN_BIT 2
`define PLL_CTRLB_FILT_MSB 1
`define PLL_CTRLB_FILT_LSB 0

// Status register bit positions.
`define PLL_STAT_LOCK_BIT 0
`define PLL_STAT_CLKRDY_BIT 1
`define PLL_STAT_ENABLE_BIT 2
`define PLL_STAT_DIV_BIT 3

// Event register bit position (write one to clear).
`define PLL_EVT_TIMEOUT_BIT 0

// Lock timeout field codes.
`define PLL_LOCK_TIMEOUT_SEL_NONE 3'h0
`define PLL_LOCK_TIMEOUT_SEL_FIRST 3'h4
`define PLL_LOCK_TIMEOUT_SEL_FIRST_MS 8

// Timing in nanoseconds and the clock period.
`define PLL_CLK_PERIOD_NS 25
`define PLL_MS_NS 1000000
`define PLL_STARTUP_NS 400
`define PLL_ENABLE_SYNC_NS 100
`define PLL_STARTUP_CYCLES ((`PLL_STARTUP_NS + `PLL_CLK_PERIOD_NS - 1) / `PLL_CLK_PERIOD_NS)
`define PLL_ENABLE_SYNC_CYCLES \
   ((`PLL_ENABLE_SYNC_NS + `PLL_CLK_PERIOD_NS - 1) / `PLL_CLK_PERIOD_NS)
`define PLL_MS_CYCLES (`PLL_MS_NS / `PLL_CLK_PERIOD_NS)

`endif

/* hdl/pll_ctrl_pkg.sv */
// Types shared by the PLL control block.
package pll_ctrl_pkg;

   // Loop sequencing states, Gray coded along off, startup, locking, running.
   typedef enum logic [1:0] {
      ST_OFF = 2'h0,
      ST_STARTUP = 2'h1,
      ST_LOCKING = 2'h3,
      ST_RUN = 2'h2
   } pll_state_t;

   // Reference clock choice.
   typedef enum logic [1:0] {
      REF_FIRST = 2'h0,
      REF_SECOND = 2'h1,
      REF_GENERIC = 2'h2,
      REF_NONE = 2'h3
   } ref_sel_t;

endpackage

/* hdl/pin_sync3.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps

module pin_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_r; // Metastability catcher, read only by stage two.
   logic [WIDTH-1:0] stage2_r; // Second stage.
   logic [WIDTH-1:0] stage3_r; // Third stage.
   logic [WIDTH-1:0] out_r; // Filtered value.
   logic [WIDTH-1:0] out_nxt; // Next filtered value.

   // A bit follows the input only when the last two stages agree.
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         assign out_nxt[gi] = (stage2_r[gi] == stage3_r[gi]) ? stage3_r[gi] : out_r[gi];
      end
   endgenerate

   // Shift chain and filtered output.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
         out_r <= '0;
      end else begin
         stage1_r <= async_in;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         out_r <= out_nxt;
      end
   end

   assign sync_out = out_r;

endmodule // pin_sync3

/* hdl/fractional_pll_control_regs.sv */
// Control registers and sequencing for the fractional digital PLL.
//
// Behaviour
// [RL1] On-request clear: run whenever enabled.
// [RL2] On-request set: run only while requested.
// [RL3] Control A at 0x44, resets 0x80.
// [RL4] Enable changes appear in status after delay.
// [RL5] Ratio integer part in bits 11:0.
// [RL6] Ratio fraction part in bits 19:16.
// [RL7] Ratio register at 0x48, resets zero.
// [RL8] Control B at 0x4c, resets zero.
// [RL9] Unused bits always read back zero.
// [RL10] Reference divided by two times (field+1).
// [RL11] Lock bypass keeps gated clock running.
// [RL12] Lock timeout codes: none, 8 to 11 ms.
// [RL13] Reference select: first, second, generic.
// [RL14] Fast wakeup gates output only through startup; the gate here still needs lock unless bypass is set.
`timescale 1ns/1ps
`include "pll_consts.svh"

module fractional_pll_control_regs
   import pll_ctrl_pkg::*;
#(
   parameter int CYCLES_PER_MS = `PLL_MS_NS / `PLL_CLK_PERIOD_NS,
   parameter int STARTUP_CYCLES = `PLL_STARTUP_CYCLES,
   parameter int ENABLE_SYNC_CYCLES = `PLL_ENABLE_SYNC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Loop side inputs from the analog domain and the clock requesters.
   input wire logic pll_lock,
   input wire logic periph_request,
   // Loop controls.
   output logic pll_run,
   output logic gated_output_clock_en,
   output logic [11:0] loop_ratio_integer,
   output logic [3:0] loop_ratio_fraction,
   output logic [12:0] ref_div_factor,
   output logic ref_div_active,
   output logic [1:0] reference_select,
   output logic low_power_mode,
   output logic [1:0] filter_select,
   output logic lock_timed_out
);

   // Reset release: asynchronous assert, two-flop synchronous release.
   logic rst_meta_r; // First stage of the release chain.
   logic rst_sync_r; // Reset copy that the rest of the block uses.

   // Assertion is immediate; release waits two edges so no flop sees a runt release.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Lock and request arrive from other domains, so they are filtered.
   logic [1:0] pin_sync; // Bit 1 request, bit 0 lock.
   logic lock_s; // Synchronised lock.
   logic req_s; // Synchronised peripheral request.

   pin_sync3 #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_sync_r),
      .async_in({periph_request, pll_lock}),
      .sync_out(pin_sync)
   );

   assign lock_s = pin_sync[0];
   assign req_s = pin_sync[1];

   // Byte-lane merge of a write into a register, restricted to its writable bits.
   function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb,
                                               input logic [31:0] mask);
      logic [31:0] lane;
      lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge_write = ((new_val & lane) | (old_val & ~lane)) & mask;
   endfunction

   // Register storage.
   logic [31:0] ctrl_a_r; // First control register.
   logic [31:0] ctrl_a_nxt; // Its next value.
   logic [31:0] ratio_r; // Ratio register.
   logic [31:0] ratio_nxt; // Its next value.
   logic [31:0] ctrl_b_r; // Second control register.
   logic [31:0] ctrl_b_nxt; // Its next value.

   // Bus decode. A write takes effect only at the completing access edge.
   logic setup_phase; // Setup cycle of a new transfer.
   logic access_done; // Completing edge of a transfer.
   logic wr_done; // Completing write.
   logic hit_ctrl_a; // Address selects first control register.
   logic hit_ratio; // Address selects ratio register.
   logic hit_ctrl_b; // Address selects second control register.
   logic hit_status; // Address selects status register.
   logic hit_event; // Address selects event register.
   logic addr_mapped; // Any register selected.

   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_done = access_done && pwrite;
   assign hit_ctrl_a = (paddr == `PLL_CTRLA_OFFSET); // [RL3]
   assign hit_ratio = (paddr == `PLL_RATIO_OFFSET); // [RL7]
   assign hit_ctrl_b = (paddr == `PLL_CTRLB_OFFSET); // [RL8]
   assign hit_status = (paddr == `PLL_STATUS_OFFSET);
   assign hit_event = (paddr == `PLL_EVENT_OFFSET);
   assign addr_mapped = hit_ctrl_a || hit_ratio || hit_ctrl_b || hit_status || hit_event;

   // Masked writes keep every unused bit at zero, so reads return zero there.
   assign ctrl_a_nxt = (wr_done && hit_ctrl_a) ?
      merge_write(ctrl_a_r, pwdata, pstrb, `PLL_CTRLA_MASK) : ctrl_a_r; // [RL9]
   assign ratio_nxt = (wr_done && hit_ratio) ?
      merge_write(ratio_r, pwdata, pstrb, `PLL_RATIO_MASK) : ratio_r; // [RL9]
   assign ctrl_b_nxt = (wr_done && hit_ctrl_b) ?
      merge_write(ctrl_b_r, pwdata, pstrb, `PLL_CTRLB_MASK) : ctrl_b_r; // [RL9]

   // Register update.
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_a_r <= `PLL_CTRLA_RESET; // [RL3]
         ratio_r <= `PLL_RATIO_RESET; // [RL7]
         ctrl_b_r <= `PLL_CTRLB_RESET; // [RL8]
      end else begin
         ctrl_a_r <= ctrl_a_nxt;
         ratio_r <= ratio_nxt;
         ctrl_b_r <= ctrl_b_nxt;
      end
   end

   // Field views of the control registers.
   logic enable_bit; // Software enable.
   logic on_request_bit; // Run only on request.
   logic bypass_bit; // Lock gate bypass.
   logic fast_wakeup; // Open the gate after startup, given lock or bypass.
   logic [2:0] lock_timeout_sel; // Lock timeout code.
   logic [10:0] div_field; // Reference divider field.
   ref_sel_t ref_sel; // Reference choice.

   assign enable_bit = ctrl_a_r[`PLL_CTRLA_ENABLE_BIT];
   assign on_request_bit = ctrl_a_r[`PLL_CTRLA_ONREQ_BIT];
   assign bypass_bit = ctrl_b_r[`PLL_CTRLB_BYPASS_BIT];
   assign fast_wakeup = ctrl_b_r[`PLL_CTRLB_WUF_BIT];
   assign lock_timeout_sel = ctrl_b_r[`PLL_CTRLB_LOCK_TIMEOUT_SEL_MSB:`PLL_CTRLB_LOCK_TIMEOUT_SEL_LSB];
   assign div_field = ctrl_b_r[`PLL_CTRLB_DIV_MSB:`PLL_CTRLB_DIV_LSB];
   assign ref_sel = ref_sel_t'(ctrl_b_r[`PLL_CTRLB_REF_MSB:`PLL_CTRLB_REF_LSB]);

   // Enable status follows the enable bit only after a settling delay.
   // Software must poll the status bit; the bit alone says nothing yet.
   logic enable_status_r; // Settled enable state.
   logic enable_status_nxt; // Its next value.
   logic [7:0] en_cnt_r; // Cycles for which the enable bit has differed from status.
   logic [7:0] en_cnt_nxt; // Its next value.
   logic en_pending; // Enable bit and status disagree.

   assign en_pending = (enable_bit != enable_status_r);
   assign en_cnt_nxt = !en_pending ? 8'h00 : (en_cnt_r + 8'h01);
   assign enable_status_nxt = (en_pending && (en_cnt_r >= 8'(ENABLE_SYNC_CYCLES - 1))) ?
      enable_bit : enable_status_r; // [RL4]

   // Settling counter; a bit flipped back before settling restarts the wait.
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         en_cnt_r <= 8'h00;
         enable_status_r <= 1'b0;
      end else begin
         en_cnt_r <= en_cnt_nxt;
         enable_status_r <= enable_status_nxt;
      end
   end

   // Run demand: the settled enable gates everything; requests only matter on request mode.
   logic run_demand; // Loop should be running.

   assign run_demand = enable_status_r && (!on_request_bit || req_s); // [RL1] [RL2]

   // Lock timeout in cycles from the selected code; 0 and reserved codes disable it.
   logic timeout_on; // A timeout code is selected.
   logic [19:0] timeout_limit; // Cycles allowed for lock.

   assign timeout_on = lock_timeout_sel >= `PLL_LOCK_TIMEOUT_SEL_FIRST; // [RL12]
   assign timeout_limit = 20'((32'(`PLL_LOCK_TIMEOUT_SEL_FIRST_MS) + 32'(lock_timeout_sel)
      - 32'(`PLL_LOCK_TIMEOUT_SEL_FIRST)) * 32'(CYCLES_PER_MS)); // [RL12]

   // Sequencer state.
   pll_state_t state_r; // Current state.
   pll_state_t state_nxt; // Next state.
   logic [19:0] seq_cnt_r; // Startup or lock wait counter.
   logic [19:0] seq_cnt_nxt; // Its next value.
   logic startup_done; // Startup time elapsed.
   logic timeout_hit; // Lock wait ran out.

   assign startup_done = seq_cnt_r >= 20'(STARTUP_CYCLES - 1);
   assign timeout_hit = (state_r == ST_LOCKING) && timeout_on && !lock_s &&
      (seq_cnt_r >= timeout_limit - 20'h1); // [RL12]

   // Next state. Losing demand always returns to off from any state.
   always_comb begin
      state_nxt = state_r;
      seq_cnt_nxt = seq_cnt_r + 20'h1;
      case (state_r)
         ST_OFF: begin
            seq_cnt_nxt = 20'h0;
            if (run_demand) begin
               state_nxt = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (!run_demand) begin
               state_nxt = ST_OFF;
            end else if (startup_done) begin
               state_nxt = ST_LOCKING;
               seq_cnt_nxt = 20'h0;
            end
         end
         ST_LOCKING: begin
            // The wait counter stops at the timeout, so timeout_hit stays high until lock or lost demand.
            if (!run_demand) begin
               state_nxt = ST_OFF;
            end else if (lock_s) begin
               state_nxt = ST_RUN;
            end else if (timeout_hit) begin
               seq_cnt_nxt = seq_cnt_r;
            end
         end
         ST_RUN: begin
            seq_cnt_nxt = 20'h0;
            if (!run_demand) begin
               state_nxt = ST_OFF;
            end
         end
         default: begin
            state_nxt = ST_OFF;
            seq_cnt_nxt = 20'h0;
         end
      endcase
   end

   // State and counter flops.
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= ST_OFF;
         seq_cnt_r <= 20'h0;
      end else begin
         state_r <= state_nxt;
         seq_cnt_r <= seq_cnt_nxt;
      end
   end

   // Output gate: slow wakeup waits for lock, fast wakeup opens after startup.
   // A low lock keeps it closed, or closes it once open, unless bypass is set.
   logic gate_phase; // Sequencer allows the gate to open.
   logic gate_nxt; // Next gate enable.

   assign gate_phase = (state_r == ST_RUN) ||
      (fast_wakeup && (state_r == ST_LOCKING)); // [RL14]
   assign gate_nxt = gate_phase && (lock_s || bypass_bit); // [RL11]

   // Sticky timeout event; a new timeout in the clearing cycle wins.
   logic timeout_evt_r; // Sticky timeout flag.
   logic timeout_evt_nxt; // Its next value.
   logic timeout_clr; // Software writes one to clear.

   assign timeout_clr = wr_done && hit_event && pstrb[0] && pwdata[`PLL_EVT_TIMEOUT_BIT];
   assign timeout_evt_nxt = timeout_hit || (timeout_evt_r && !timeout_clr);

   // Reference divider factor and whether the divided reference is in use.
   logic [12:0] div_factor_nxt; // Two times (field plus one).

   assign div_factor_nxt = {1'b0, div_field, 1'b0} + 13'h2; // [RL10]

   // Read mux, evaluated in the setup cycle and held through access.
   logic [31:0] status_word; // Live status.
   logic [31:0] event_word; // Sticky events.
   logic [31:0] read_word; // Selected register.

   assign status_word = {28'h0, ref_div_active, enable_status_r, gated_output_clock_en,
      lock_s}; // [RL4]
   assign event_word = {31'h0, timeout_evt_r};
   assign read_word = hit_ctrl_a ? ctrl_a_r :
      hit_ratio ? ratio_r :
      hit_ctrl_b ? ctrl_b_r :
      hit_status ? status_word :
      hit_event ? event_word : 32'h0; // [RL9]

   // Output flops. Every top output is registered.
   // The slave adds exactly one wait-free access: pready rises in the access cycle.
   always_ff @(posedge clk_sys or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         timeout_evt_r <= 1'b0;
         pll_run <= 1'b0;
         gated_output_clock_en <= 1'b0;
         loop_ratio_integer <= 12'h0;
         loop_ratio_fraction <= 4'h0;
         ref_div_factor <= 13'h2;
         ref_div_active <= 1'b0;
         reference_select <= 2'h0;
         low_power_mode <= 1'b0;
         filter_select <= 2'h0;
         lock_timed_out <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase && !addr_mapped;
         if (setup_phase) begin
            // Writes return zero data; reads capture the register at setup.
            prdata <= pwrite ? 32'h0 : read_word;
         end
         timeout_evt_r <= timeout_evt_nxt;
         pll_run <= (state_nxt != ST_OFF); // [RL1] [RL2]
         gated_output_clock_en <= gate_nxt;
         loop_ratio_integer <= ratio_r[`PLL_RATIO_INT_MSB:`PLL_RATIO_INT_LSB]; // [RL5]
         loop_ratio_fraction <= ratio_r[`PLL_RATIO_FRAC_MSB:`PLL_RATIO_FRAC_LSB]; // [RL6]
         ref_div_factor <= div_factor_nxt; // [RL10]
         ref_div_active <= (ref_sel == REF_SECOND); // [RL10]
         // The reserved reference code leaves the previous selection in place.
         if (ref_sel != REF_NONE) begin
            reference_select <= ref_sel; // [RL13]
         end
         low_power_mode <= ctrl_b_r[`PLL_CTRLB_LPEN_BIT];
         filter_select <= ctrl_b_r[`PLL_CTRLB_FILT_MSB:`PLL_CTRLB_FILT_LSB];
         lock_timed_out <= timeout_evt_nxt;
      end
   end

endmodule // fractional_pll_control_regs

/* testbench/pll_ctrl_sva.sv */
// Checker of bus timing and loop control outputs of the PLL control block.
`timescale 1ns/1ps

module pll_ctrl_sva (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pll_run,
   input wire logic gated_output_clock_en,
   input wire logic [11:0] loop_ratio_integer,
   input wire logic [12:0] ref_div_factor,
   input wire logic lock_timed_out
);
   // A completed transfer; writes are decoded from it.
   wire acc = psel && penable && pready;
   // Write of the ratio register.
   wire wr_ratio = acc && pwrite && paddr == 12'h048;
   // Write of one to the timeout event bit.
   wire clr_evt = acc && pwrite && paddr == 12'h054 && pstrb[0] && pwdata[0];
   // Enable written with run on request cleared.
   wire en_cont = acc && pwrite && paddr == 12'h044 && pstrb[0] && pwdata[7:0] == 8'h02;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read returned data");
   a_ratio_by_write: assert property ($changed(loop_ratio_integer) |->
      $past(wr_ratio, 1) || $past(wr_ratio, 2))
      else $error("ratio output changed without write");
   a_div_factor: assert property (acc && pwrite && paddr == 12'h04c && pstrb == 4'hf
      |-> ##2 ref_div_factor == (13'($past(pwdata[26:16], 2)) + 13'h1) * 13'h2)
      else $error("divide factor not twice field plus one");
   a_run_when_enabled: assert property (en_cont |-> ##[4:8] pll_run)
      else $error("loop not started after enable");
   a_gate_needs_run: assert property ($rose(gated_output_clock_en) |->
      pll_run || $past(pll_run))
      else $error("gate opened with loop off");
   a_timeout_sticky: assert property ($fell(lock_timed_out) |->
      $past(clr_evt, 1) || $past(clr_evt, 2))
      else $error("timeout flag dropped without clear");

   c_error: cover property (pslverr);
   c_gate: cover property ($rose(gated_output_clock_en));
   c_timeout: cover property ($rose(lock_timed_out));
endmodule // pll_ctrl_sva

/* testbench/fractional_pll_control_regs_tb_top.sv */
// Self-checking testbench of the PLL control register block.
`timescale 1ns/1ps

module fractional_pll_control_regs_tb_top;
   logic clk_sys = 1'b0; // Bus clock, 40 MHz.
   logic rst_n = 1'b0; // Reset held from time zero.
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic pll_lock = 1'b0;
   logic periph_request = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, pll_run, gated_output_clock_en;
   logic ref_div_active, low_power_mode, lock_timed_out;
   logic [11:0] loop_ratio_integer;
   logic [3:0] loop_ratio_fraction;
   logic [12:0] ref_div_factor;
   logic [1:0] reference_select, filter_select;
   int mismatches = 0;
   int n_compared = 0;
   logic [31:0] rq; // Last read data.
   logic re; // Last error response.

   // Half period of 12.5 ns.
   always #12.5 clk_sys = ~clk_sys;

   // A short millisecond keeps the timeout runs brief.
   fractional_pll_control_regs #(.CYCLES_PER_MS(10)) fractional_pll_control_regs_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pll_lock(pll_lock), .periph_request(periph_request),
      .pll_run(pll_run), .gated_output_clock_en(gated_output_clock_en),
      .loop_ratio_integer(loop_ratio_integer), .loop_ratio_fraction(loop_ratio_fraction),
      .ref_div_factor(ref_div_factor), .ref_div_active(ref_div_active),
      .reference_select(reference_select), .low_power_mode(low_power_mode),
      .filter_select(filter_select), .lock_timed_out(lock_timed_out));

   // Compares one value and counts it.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One bus transfer; the request stands until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("slverr", 32'(re),
         32'(!(a inside {12'h044, 12'h048, 12'h04c, 12'h050, 12'h054})));
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("read %h", a), rq, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Reset values of the three registers and the divider.
   task automatic t_reset();
      rd(12'h044, 32'h0000_0080);
      rd(12'h048, 32'h0000_0000);
      rd(12'h04c, 32'h0000_0000);
      chk("div factor", 32'(ref_div_factor), 32'h2);
      $display("test reset done");
   endtask

   // Field placement, reserved bits and decoded outputs.
   task automatic t_fields();
      wr(12'h048, 32'hffff_ffff);
      rd(12'h048, 32'h000f_0fff);
      wr(12'h048, 32'h000a_0123);
      idle(3);
      chk("ratio int", 32'(loop_ratio_integer), 32'h123);
      chk("ratio frac", 32'(loop_ratio_fraction), 32'ha);
      wr(12'h044, 32'hffff_ffff);
      rd(12'h044, 32'h0000_0082);
      wr(12'h044, 32'h0000_0080);
      wr(12'h04c, 32'hffff_ffff);
      rd(12'h04c, 32'h07ff_173f);
      idle(3);
      chk("div max", 32'(ref_div_factor), 32'h1000);
      chk("ref reserved", 32'(reference_select), 32'h0);
      chk("low power", 32'(low_power_mode), 32'h1);
      chk("filter", 32'(filter_select), 32'h3);
      wr(12'h04c, 32'h0005_0000);
      idle(3);
      chk("div five", 32'(ref_div_factor), 32'hc);
      for (int c = 0; c < 3; c++) begin
         wr(12'h04c, 32'(c) << 4);
         idle(3);
         chk("ref select", 32'(reference_select), 32'(c));
         chk("ref div on", 32'(ref_div_active), 32'(c == 1));
      end
      wr(12'h04c, 32'h0000_0000);
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk("unmapped err", 32'(re), 32'h1);
      chk("unmapped data", rq, 32'h0000_0000);
      $display("test fields done");
   endtask

   // Run on request, continuous run, enable delay and lock gating.
   task automatic t_demand();
      periph_request <= 1'b1;
      idle(30);
      chk("request while off", 32'(pll_run), 32'h0);
      periph_request <= 1'b0;
      wr(12'h044, 32'h0000_0082);
      idle(20);
      chk("no request", 32'(pll_run), 32'h0);
      periph_request <= 1'b1;
      idle(12);
      chk("requested", 32'(pll_run), 32'h1);
      periph_request <= 1'b0;
      idle(10);
      chk("released", 32'(pll_run), 32'h0);
      wr(12'h044, 32'h0000_0002);
      idle(3);
      chk("continuous", 32'(pll_run), 32'h1);
      rd(12'h050, 32'h0000_0004);
      pll_lock <= 1'b1;
      idle(30);
      chk("gate locked", 32'(gated_output_clock_en), 32'h1);
      pll_lock <= 1'b0;
      idle(8);
      chk("gate unlocked", 32'(gated_output_clock_en), 32'h0);
      wr(12'h04c, 32'h0000_1000);
      idle(4);
      chk("gate bypass", 32'(gated_output_clock_en), 32'h1);
      wr(12'h044, 32'h0000_0000);
      rd(12'h050, 32'h0000_0006);
      idle(10);
      chk("disabled", 32'(pll_run), 32'h0);
      rd(12'h050, 32'h0000_0000);
      $display("test demand done");
   endtask

   // Gating through startup only, with lock never reached.
   task automatic t_wakeup();
      wr(12'h044, 32'h0000_0002);
      idle(40);
      chk("slow wakeup", 32'(gated_output_clock_en), 32'h0);
      wr(12'h04c, 32'h0000_1008);
      idle(4);
      chk("fast wakeup", 32'(gated_output_clock_en), 32'h1);
      wr(12'h044, 32'h0000_0000);
      wr(12'h04c, 32'h0000_0000);
      idle(10);
      $display("test wakeup done");
   endtask

   // Every timeout code; the wait spans startup plus the coded milliseconds.
   task automatic t_timeout();
      int n;
      for (int c = 4; c < 8; c++) begin
         wr(12'h04c, 32'(c) << 8);
         wr(12'h054, 32'h0000_0001);
         wr(12'h044, 32'h0000_0002);
         n = 0;
         while (lock_timed_out !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
         end
         chk("timeout span", 32'(n >= (c + 4) * 10 + 18 && n <= (c + 4) * 10 + 26), 32'h1);
         wr(12'h044, 32'h0000_0000);
         idle(8);
         wr(12'h054, 32'h0000_0001);
         idle(2);
         chk("timeout clear", 32'(lock_timed_out), 32'h0);
      end
      wr(12'h04c, 32'h0000_0000);
      wr(12'h044, 32'h0000_0002);
      idle(200);
      chk("no timeout", 32'(lock_timed_out), 32'h0);
      wr(12'h044, 32'h0000_0000);
      $display("test timeout done");
   endtask

   // Main sequence.
   initial begin
      idle(8);
      rst_n <= 1'b1;
      idle(8);
      t_reset();
      t_fields();
      t_demand();
      t_wakeup();
      t_timeout();
      conclude();
   end

   // The whole run is about a thousand cycles; this cuts a hang short.
   initial begin
      idle(20000);
      mismatches++;
      conclude();
   end
endmodule // fractional_pll_control_regs_tb_top

bind fractional_pll_control_regs pll_ctrl_sva pll_ctrl_sva_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pll_run(pll_run), .gated_output_clock_en(gated_output_clock_en),
   .loop_ratio_integer(loop_ratio_integer), .ref_div_factor(ref_div_factor),
   .lock_timed_out(lock_timed_out));
